/* File: host_port.sv */
/*
  Device end of the 16-bit SRAM-like host port: pin sampling, cycle framing,
  register and FIFO access strobes, read data drive and write-to-read spacing watch.
  Assumes the core answers reg_rd_data one cycle after a read strobe and applies
  writes and pushes in the cycle they are strobed.
*/
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Register reads, burst reads and direct receive-FIFO reads (single or burst) are framed by chip select together with the read strobe.
// - Register writes and direct transmit-FIFO writes are framed by chip select together with the write strobe.
// - A transmit-FIFO write reaches the fill-level logic well inside 135 ns.
// - A register read too soon after a write may see the old value, and such reads are flagged.
module host_port
  import host_port_pkg::*;
(
  // clock and reset
  input  wire logic                         core_clk,
  input  wire logic                         srst,
  // host pins
  input  wire logic                         chip_sel_low,
  input  wire logic                         read_strobe_low,
  input  wire logic                         write_strobe_low,
  input  wire logic                         fifo_sel,
  input  wire logic [host_port_pkg::ADDR_W-1:0] addr,
  input  wire logic [host_port_pkg::DATA_W-1:0] data_in,
  output logic      [host_port_pkg::DATA_W-1:0] data_out_q,
  output logic                              data_oe_q,
  // register access toward the core
  output logic                              reg_wr_q,
  output logic                              reg_rd_q,
  output logic      [host_port_pkg::ADDR_W-1:0] reg_addr_q,
  output logic      [host_port_pkg::DATA_W-1:0] reg_wr_data_q,
  input  wire logic [host_port_pkg::DATA_W-1:0] reg_rd_data,
  // direct fifo access
  output logic                              tx_push_q,
  output logic                              rx_pop_q,
  // spacing report
  output logic                              early_read_q,
  output host_port_pkg::widx_t              early_idx_q,
  output logic                              tx_level_due
);
  import host_port_pkg::*;

  // ****************************************
  // pin sampling
  // ****************************************
  logic [PIN_W-1:0] pin_s1_q;
  logic [PIN_W-1:0] pin_s2_q;
  logic [PIN_W-1:0] pin_s3_q;
  logic [PIN_W-1:0] pin_q;
  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] pin_d;

  function automatic logic [PIN_W-1:0] agree(input logic [PIN_W-1:0] a, input logic [PIN_W-1:0] b,
                                             input logic [PIN_W-1:0] held);
    return (a & b) | (held & (a ^ b));
  endfunction : agree

  assign pin_raw = {data_in, addr, fifo_sel, write_strobe_low, read_strobe_low, chip_sel_low};
  // a level moves only once stages two and three agree
  assign pin_d   = agree(pin_s2_q, pin_s3_q, pin_q);

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      pin_s1_q <= '1;
      pin_s2_q <= '1;
      pin_s3_q <= '1;
      pin_q    <= '1;
    end
    else
    begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_q    <= pin_d;
    end
  end

  // ****************************************
  // cycle framing
  // ****************************************
  wire              cs_on    = ~pin_q[PIN_CS];
  wire              fsel     = pin_q[PIN_FSEL];
  wire [ADDR_W-1:0] addr_now = pin_q[PIN_ADDR +: ADDR_W];
  wire [DATA_W-1:0] data_now = pin_q[PIN_DATA +: DATA_W];
  // read framed by select and read strobe low
  wire              rd_act   = cs_on & ~pin_q[PIN_RD];
  // write framed by select and write strobe
  wire              wr_act   = cs_on & ~pin_q[PIN_WR];

  logic              rd_act_q;
  logic              wr_act_q;
  logic              cap_fsel_q;
  logic              rd_wait_q;
  logic [ADDR_W-1:0] rd_addr_q;
  logic [ADDR_W-1:0] cap_addr_q;
  logic [DATA_W-1:0] cap_data_q;

  // a new address inside a held read starts the next burst word
  wire rd_start = rd_act & (~rd_act_q | (addr_now != rd_addr_q));
  // data is taken at the strobe's rising end, once the host has settled it
  wire wr_end   = wr_act_q & ~wr_act;

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      rd_act_q   <= 1'b0;
      wr_act_q   <= 1'b0;
      rd_addr_q  <= '0;
      cap_addr_q <= '0;
      cap_data_q <= '0;
      cap_fsel_q <= 1'b0;
    end
    else
    begin
      rd_act_q  <= rd_act;
      wr_act_q  <= wr_act;
      rd_addr_q <= addr_now;
      // last sample before the strobe rises is the written word
      if (wr_act)
      begin
        cap_addr_q <= addr_now;
        cap_data_q <= data_now;
        cap_fsel_q <= fsel;
      end
    end
  end

  // ****************************************
  // core strobes and read data
  // ****************************************
  // write committed the cycle after the strobe ends
  wire              reg_wr_d   = wr_end & ~cap_fsel_q;
  // push reaches the fill logic the cycle after the strobe ends
  wire              tx_push_d  = wr_end & cap_fsel_q;
  wire              reg_rd_d   = rd_start & ~fsel;
  // direct fifo read ignores upper address
  wire              rx_pop_d   = rd_start & fsel;
  // core answers one cycle after its pulse
  wire              rd_answer  = reg_rd_q | rx_pop_q;
  // a write end wins so its address travels with its pulse
  wire [ADDR_W-1:0] reg_addr_d = wr_end ? cap_addr_q : (rd_start ? addr_now : reg_addr_q);

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      reg_wr_q  <= 1'b0;
      tx_push_q <= 1'b0;
      reg_rd_q  <= 1'b0;
      rx_pop_q  <= 1'b0;
      rd_wait_q <= 1'b0;
      data_oe_q <= 1'b0;
    end
    else
    begin
      reg_wr_q  <= reg_wr_d;
      tx_push_q <= tx_push_d;
      reg_rd_q  <= reg_rd_d;
      rx_pop_q  <= rx_pop_d;
      rd_wait_q <= rd_answer;
      data_oe_q <= rd_act;
    end
  end

  // ****************************************
  // held address and data words
  // ****************************************
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      reg_addr_q    <= '0;
      reg_wr_data_q <= '0;
      data_out_q    <= '0;
    end
    else
    begin
      reg_addr_q <= reg_addr_d;
      if (wr_end)
      begin
        reg_wr_data_q <= cap_data_q;
      end
      // read word taken in the cycle the core presents it
      if (rd_wait_q)
      begin
        data_out_q <= reg_rd_data;
      end
    end
  end

  // ****************************************
  // spacing watch
  // ****************************************
  cnt_t since_write;

  // flag only: an early read still proceeds, so host throughput is kept
  // reads inside the wait are reported, not blocked
  spacing_tracker u_tracker (
    .core_clk      (core_clk),
    .srst          (srst),
    .write_done    (wr_end),
    .read_start    (rd_start),
    .read_fifo     (fsel),
    .read_idx      (addr_now[ADDR_W-1:1]),
    .early_read_q  (early_read_q),
    .early_idx_q   (early_idx_q),
    .since_write_q (since_write)
  );

  // fill level may still be settling after a push
  assign tx_level_due = (since_write < TXLVL_CYC) & cap_fsel_q;
endmodule : host_port

`default_nettype wire

/* File: spacing_tracker.sv */
/*
  Holds the shared package for the host port and the write-to-read spacing tracker.
  Assumes a single 125 MHz core clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none

package host_port_pkg;
  // ****************************************
  // pins and widths
  // ****************************************
  localparam int unsigned DATA_W    = 16;
  localparam int unsigned ADDR_W    = 7;
  localparam int unsigned PIN_W     = 4 + ADDR_W + DATA_W;
  localparam int unsigned PIN_CS    = 0;
  localparam int unsigned PIN_RD    = 1;
  localparam int unsigned PIN_WR    = 2;
  localparam int unsigned PIN_FSEL  = 3;
  localparam int unsigned PIN_ADDR  = 4;
  localparam int unsigned PIN_DATA  = PIN_ADDR + ADDR_W;
  localparam int unsigned WIDX_W    = ADDR_W - 1;

  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_NS    = 8;
  localparam int unsigned WAIT0_NS  = 0;
  localparam int unsigned WAIT1_NS  = 45;
  localparam int unsigned WAIT2_NS  = 90;
  localparam int unsigned WAIT3_NS  = 135;
  localparam int unsigned WAIT4_NS  = 180;
  localparam int unsigned WAIT7_NS  = 315;
  localparam int unsigned TXLVL_NS  = 135;
  localparam int unsigned CNT_W     = 6;
  typedef logic [CNT_W-1:0] cnt_t;
  // longest times round down: the device must be settled by then
  localparam cnt_t WAIT0_CYC = cnt_t'(WAIT0_NS / CLK_NS);
  localparam cnt_t WAIT1_CYC = cnt_t'(WAIT1_NS / CLK_NS);
  localparam cnt_t WAIT2_CYC = cnt_t'(WAIT2_NS / CLK_NS);
  localparam cnt_t WAIT3_CYC = cnt_t'(WAIT3_NS / CLK_NS);
  localparam cnt_t WAIT4_CYC = cnt_t'(WAIT4_NS / CLK_NS);
  localparam cnt_t WAIT7_CYC = cnt_t'(WAIT7_NS / CLK_NS);
  localparam cnt_t TXLVL_CYC = cnt_t'(TXLVL_NS / CLK_NS);
  localparam cnt_t CNT_MAX   = {CNT_W{1'b1}};

  // ****************************************
  // word indices (address bits 6:1)
  // ****************************************
  typedef logic [WIDX_W-1:0] widx_t;
  localparam widx_t IDX_CHIP_IDENT = 6'h14;
  localparam widx_t IDX_IRQ_CFG    = 6'h15;
  localparam widx_t IDX_INT_STATUS = 6'h16;
  localparam widx_t IDX_ENDIAN     = 6'h19;
  localparam widx_t IDX_RX_FILL    = 6'h1f;
  localparam widx_t IDX_TX_FILL    = 6'h20;
  localparam widx_t IDX_PWR_MGMT   = 6'h21;
  localparam widx_t IDX_GPT_COUNT  = 6'h24;
  localparam widx_t IDX_FREE_RUN   = 6'h27;
  localparam widx_t IDX_RX_DROP    = 6'h28;

  function automatic cnt_t wait_for(input widx_t idx);
    cnt_t w;
    w = WAIT1_CYC;
    case (idx)
      IDX_CHIP_IDENT, IDX_ENDIAN, IDX_RX_FILL, IDX_RX_DROP: w = WAIT0_CYC;
      IDX_IRQ_CFG, IDX_TX_FILL, IDX_GPT_COUNT:             w = WAIT3_CYC;
      IDX_INT_STATUS:                                      w = WAIT2_CYC;
      IDX_PWR_MGMT:                                        w = WAIT7_CYC;
      IDX_FREE_RUN:                                        w = WAIT4_CYC;
      default:                                             w = WAIT1_CYC;
    endcase
    return w;
  endfunction : wait_for
endpackage : host_port_pkg

module spacing_tracker
  import host_port_pkg::*;
(
  // clock and reset
  input  wire logic                core_clk,
  input  wire logic                srst,
  // events
  input  wire logic                write_done,
  input  wire logic                read_start,
  input  wire logic                read_fifo,
  input  wire host_port_pkg::widx_t read_idx,
  // report
  output logic                     early_read_q,
  output host_port_pkg::widx_t     early_idx_q,
  output host_port_pkg::cnt_t      since_write_q
);
  import host_port_pkg::*;

  cnt_t  since_d;
  logic  early_d;

  // ****************************************
  // cycles since the end of the latest write
  // ****************************************
  // count from end of last write
  assign since_d = write_done ? '0 : (since_write_q == CNT_MAX ? CNT_MAX : since_write_q + cnt_t'(1));
  assign early_d = read_start & ~read_fifo & (since_write_q < wait_for(read_idx));

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      since_write_q <= CNT_MAX;
      early_read_q  <= 1'b0;
      early_idx_q   <= '0;
    end
    else
    begin
      since_write_q <= since_d;
      early_read_q  <= early_d;
      if (early_d)
      begin
        early_idx_q <= read_idx;
      end
    end
  end
endmodule : spacing_tracker

`default_nettype wire

/* File: host_port_sva.sv */
/* checker for the host port spacing and strobes; assumes host_port_pkg is compiled first */
`timescale 1ns/1ps
`default_nettype none
module host_port_sva
  import host_port_pkg::*;
(
  // pins and core side; read strobe, fifo_sel, addr, data_in and reg_wr_data_q are not checked
  input wire logic              core_clk, srst, chip_sel_low, read_strobe_low, write_strobe_low, fifo_sel,
  input wire logic [ADDR_W-1:0] addr, reg_addr_q,
  input wire logic [DATA_W-1:0] data_in, data_out_q, reg_wr_data_q, reg_rd_data,
  input wire logic              data_oe_q, reg_wr_q, reg_rd_q, tx_push_q, rx_pop_q, early_read_q, tx_level_due,
  input wire widx_t             early_idx_q
);
  // ****************************************
  // cycles since the last write
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  cnt_t gap_q;
  wire widx_t ridx = reg_addr_q[ADDR_W-1:1];
  // margin of 3 absorbs the one-edge skew between read start and flag
  always_ff @(posedge core_clk)
    if (srst) gap_q <= CNT_MAX;
    else if (reg_wr_q || tx_push_q) gap_q <= '0;
    else if (gap_q != CNT_MAX) gap_q <= gap_q + 1'b1;

  chk_rd_data_lat: assert property (reg_rd_q |-> ##2 data_out_q == $past(reg_rd_data))
    else $error("read data late or wrong");
  chk_rd_drives_bus: assert property (reg_rd_q |-> data_oe_q)
    else $error("bus not driven during read");
  chk_wr_after_end: assert property ($rose(write_strobe_low) && $past(chip_sel_low) == 1'b0
    |-> ##[3:6] (reg_wr_q || tx_push_q))
    else $error("write end not committed");
  chk_push_not_reg: assert property (tx_push_q |-> !reg_wr_q)
    else $error("fifo push also wrote a register");
  chk_tx_level_due: assert property (tx_push_q |=> tx_level_due [*8])
    else $error("tx level settle window too short");
  chk_early_on_read: assert property (early_read_q |-> reg_rd_q && !rx_pop_q)
    else $error("early flag without register read");
  chk_early_index: assert property (early_read_q |-> ##[0:1] early_idx_q == ridx)
    else $error("early index wrong");
  chk_early_power: assert property (reg_rd_q && ridx == IDX_PWR_MGMT && gap_q < WAIT7_CYC - 3
    |-> early_read_q)
    else $error("early power read not flagged");
  chk_late_no_flag: assert property (reg_rd_q && gap_q > WAIT7_CYC + 3 |-> !early_read_q)
    else $error("read after longest wait flagged");
  chk_ident_no_wait: assert property (reg_rd_q && ridx == IDX_CHIP_IDENT |-> !early_read_q)
    else $error("ident read flagged");
  cover property (early_read_q);
  cover property (tx_push_q);
  cover property (rx_pop_q);
endmodule : host_port_sva

bind host_port host_port_sva i_sva (
  .core_clk         (core_clk),
  .srst             (srst),
  .chip_sel_low     (chip_sel_low),
  .read_strobe_low  (read_strobe_low),
  .write_strobe_low (write_strobe_low),
  .fifo_sel         (fifo_sel),
  .addr             (addr),
  .reg_addr_q       (reg_addr_q),
  .data_in          (data_in),
  .data_out_q       (data_out_q),
  .reg_wr_data_q    (reg_wr_data_q),
  .reg_rd_data      (reg_rd_data),
  .data_oe_q        (data_oe_q),
  .reg_wr_q         (reg_wr_q),
  .reg_rd_q         (reg_rd_q),
  .tx_push_q        (tx_push_q),
  .rx_pop_q         (rx_pop_q),
  .early_read_q     (early_read_q),
  .tx_level_due     (tx_level_due),
  .early_idx_q      (early_idx_q)
);
`default_nettype wire

/* File: host_model.sv */
/* host processor model driving the port pins; assumes the 125 MHz core clock */
`timescale 1ns/1ps
`default_nettype none
module host_model
  import host_port_pkg::*;
(
  input  wire logic              core_clk,
  output logic                   chip_sel_low, read_strobe_low, write_strobe_low, fifo_sel,
  output logic [ADDR_W-1:0]      addr,
  output logic [DATA_W-1:0]      data_in
);
  // ****************************************
  // one framed access, then idle
  // ****************************************
  initial {chip_sel_low, read_strobe_low, write_strobe_low, fifo_sel, addr, data_in} = {4'he, 23'h0};
  task automatic access(input logic wr, input widx_t idx, input logic fsel, input logic [DATA_W-1:0] d,
                        input int idle);
    @(posedge core_clk);
    addr <= {idx, 1'b0};
    fifo_sel <= fsel;
    data_in <= wr ? d : ~data_in;
    chip_sel_low <= 1'b0;
    if (wr) write_strobe_low <= 1'b0;
    else read_strobe_low <= 1'b0;
    repeat (6) @(posedge core_clk);
    {chip_sel_low, read_strobe_low, write_strobe_low} <= 3'h7;
    // released bus must not keep the last word
    data_in <= ~data_in;
    repeat (2 + idle) @(posedge core_clk);
  endtask : access
  task automatic burst(input widx_t idx_a, input widx_t idx_b);
    @(posedge core_clk);
    addr <= {idx_a, 1'b0};
    fifo_sel <= 1'b0;
    chip_sel_low <= 1'b0;
    read_strobe_low <= 1'b0;
    repeat (6) @(posedge core_clk);
    addr <= {idx_b, 1'b0};
    repeat (6) @(posedge core_clk);
    {chip_sel_low, read_strobe_low} <= 2'h3;
    repeat (2) @(posedge core_clk);
  endtask : burst
endmodule : host_model
`default_nettype wire

/* File: host_port_tb.sv */
/* self-checking bench for host_port; assumes host_model and the bound checker */
`timescale 1ns/1ps
`default_nettype none
module host_port_tb;
  import host_port_pkg::*;
  logic core_clk, srst, chip_sel_low, read_strobe_low, write_strobe_low, fifo_sel;
  logic data_oe_q, reg_wr_q, reg_rd_q, tx_push_q, rx_pop_q, early_read_q, tx_level_due;
  logic [ADDR_W-1:0] addr, reg_addr_q;
  logic [DATA_W-1:0] data_in, data_out_q, reg_wr_data_q, reg_rd_data;
  widx_t early_idx_q;
  int bad_count, compares, n_rd, n_wr, n_push, n_pop, n_early;
  // ****************************************
  // clock, partner, core stand-in
  // ****************************************
  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  host_model i_host (
    .core_clk         (core_clk),
    .chip_sel_low     (chip_sel_low),
    .read_strobe_low  (read_strobe_low),
    .write_strobe_low (write_strobe_low),
    .fifo_sel         (fifo_sel),
    .addr             (addr),
    .data_in          (data_in)
  );
  host_port i_dut (
    .core_clk         (core_clk),
    .srst             (srst),
    .chip_sel_low     (chip_sel_low),
    .read_strobe_low  (read_strobe_low),
    .write_strobe_low (write_strobe_low),
    .fifo_sel         (fifo_sel),
    .addr             (addr),
    .data_in          (data_in),
    .data_out_q       (data_out_q),
    .data_oe_q        (data_oe_q),
    .reg_wr_q         (reg_wr_q),
    .reg_rd_q         (reg_rd_q),
    .reg_addr_q       (reg_addr_q),
    .reg_wr_data_q    (reg_wr_data_q),
    .reg_rd_data      (reg_rd_data),
    .tx_push_q        (tx_push_q),
    .rx_pop_q         (rx_pop_q),
    .early_read_q     (early_read_q),
    .early_idx_q      (early_idx_q),
    .tx_level_due     (tx_level_due)
  );
  always @(posedge core_clk)
  begin
    reg_rd_data <= {8'h5a, 1'b0, reg_addr_q};
    {n_rd, n_wr, n_push, n_pop, n_early} = {n_rd + reg_rd_q, n_wr + reg_wr_q, n_push + tx_push_q,
                                            n_pop + rx_pop_q, n_early + early_read_q};
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic finish_test;
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : finish_test
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_rw;
    int r = n_rd;
    int w = n_wr;
    i_host.access(0, IDX_CHIP_IDENT, 0, '0, 0);
    i_host.access(1, 6'h30, 0, 16'hbeef, 4);
    #1;
    check(16'(n_rd - r), 16'h1);
    check(data_out_q, {8'h5a, 1'b0, IDX_CHIP_IDENT, 1'b0});
    check(16'(data_oe_q), 16'h0);
    check(16'(n_wr - w), 16'h1);
    check(reg_wr_data_q, 16'hbeef);
    check(16'(reg_addr_q), 16'h0060);
    $display("test rw done");
  endtask : t_rw
  task automatic t_table;
    widx_t ids[11] = '{IDX_CHIP_IDENT, IDX_ENDIAN, IDX_RX_FILL, IDX_RX_DROP, IDX_IRQ_CFG, IDX_INT_STATUS,
                       IDX_TX_FILL, IDX_PWR_MGMT, IDX_GPT_COUNT, IDX_FREE_RUN, 6'h30};
    int e;
    foreach (ids[i])
    begin
      e = n_early;
      i_host.access(1, 6'h30, 0, 16'h0001, 0);
      i_host.access(0, ids[i], 0, '0, 0);
      #1;
      check(16'(n_early - e), (i < 4) ? 16'h0 : 16'h1);
      if (i >= 4) check(16'(early_idx_q), 16'(ids[i]));
    end
    $display("test table done");
  endtask : t_table
  task automatic t_dummy(input int n, input int idle);
    int e = n_early;
    i_host.access(1, 6'h30, 0, 16'h0002, 0);
    repeat (n) i_host.access(0, IDX_ENDIAN, 0, '0, idle);
    i_host.access(0, IDX_PWR_MGMT, 0, '0, 0);
    #1;
    check(16'(n_early - e), 16'h0);
    $display("test dummy done");
  endtask : t_dummy
  task automatic t_fifo;
    int p = n_push;
    int q = n_pop;
    int w = n_wr;
    int e = n_early;
    i_host.access(1, 6'h30, 1, 16'h00aa, 4);
    #1;
    check(16'(n_push - p), 16'h1);
    check(16'(n_wr - w), 16'h0);
    check(reg_wr_data_q, 16'h00aa);
    check(16'(tx_level_due), 16'h1);
    i_host.access(0, IDX_PWR_MGMT, 1, '0, 0);
    #1;
    check(16'(n_pop - q), 16'h1);
    check(16'(n_early - e), 16'h0);
    repeat (TXLVL_CYC) @(posedge core_clk);
    #1;
    check(16'(tx_level_due), 16'h0);
    $display("test fifo done");
  endtask : t_fifo
  task automatic t_burst;
    int r = n_rd;
    int e = n_early;
    i_host.burst(IDX_CHIP_IDENT, IDX_ENDIAN);
    #1;
    check(16'(n_rd - r), 16'h2);
    check(data_out_q, {8'h5a, 1'b0, IDX_ENDIAN, 1'b0});
    check(16'(n_early - e), 16'h0);
    repeat (4) @(posedge core_clk);
    #1;
    check(16'(data_oe_q), 16'h0);
    $display("test burst done");
  endtask : t_burst
  initial
  begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    finish_test;
  end
  initial
  begin
    srst = 1'b1;
    repeat (4) @(posedge core_clk);
    srst <= 1'b0;
    t_rw;
    t_table;
    t_dummy(7, 0);
    t_dummy(2, 20);
    t_fifo;
    t_burst;
    finish_test;
  end
endmodule : host_port_tb
`default_nettype wire
